// ---- shared/pg_thermal_defs.svh ----
// What this block does
// R1: primary drives power-good as open-drain output
// R2: secondary reads power-good as CCM go signal
// R3: window fault below 95% or above 105%
// R4: comparator deglitched about 40 us
// R5: blanking setting ignores window during scaling
// R6: power-good low on faults, disable, soft start
// R7: release only when every good condition holds
// R8: secondary presets startup-hold latch at init
// R9: start-up done clears hold, pull-down off
// R10: shared line rises, secondary sets CCM latch
// R11: disable, shutdown, lockout preset both latches; code presets them on undervoltage lockout only, not on overvoltage lockout
// R12: above 150 C sets thermal warning flag
// R13: read clears warning only below 130 C
// R14: above 170 C stop, flag, discharge, pull low
// R15: shutdown pulls enable pin when standalone-select 0
// R16: below 150 C restart, release pins
// R17: read clears shutdown flag only below 150 C
// R18: init senses sync-output pin for role
// R19: shared enable makes shutdown stop whole stack
// R20: deglitch is a stable-level counter
`ifndef PG_THERMAL_DEFS_SVH
`define PG_THERMAL_DEFS_SVH
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define CTRL_SW_ENABLE_BIT 0
`define CTRL_DISCHARGE_BIT 1
`define CTRL_BLANK_BIT 2
`define CTRL_STANDALONE_BIT 3
`define CTRL_RESET 4'h3
`define STAT_THERMAL_WARNING_FLAG_BIT 0
`define STAT_THERMAL_SHUTDOWN_FLAG_BIT 1
`define STAT_SECONDARY_BIT 2
`define STAT_PG_LOW_BIT 3
`define STAT_CCM_BIT 4
`define STAT_HOLD_BIT 5
`define STAT_WINDOW_BIT 6
`define STAT_ROLE_KNOWN_BIT 7
`define CLK_PERIOD_NS 10
`define DEGLITCH_TIME_NS 40000
`define DEGLITCH_CYCLES ((`DEGLITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- shared/pg_thermal_pkg.sv ----
package pg_thermal_pkg;
    // asynchronous analog comparator and pin levels
    typedef struct packed {
        logic enPin;
        logic powerGoodPin;
        logic syncOutputPinHigh;
        logic vBelowWindow;
        logic vAboveWindow;
        logic tAbove130;
        logic tAbove150;
        logic tAbove170;
        logic undervoltageLockout;
        logic overvoltageLockout;
    } pins_t;
    // state reported by converter logic on the same clock
    typedef struct packed {
        logic softStartActive;
        logic dynamicVoltageTransition;
        logic hiccupActive;
        logic startupDone;
    } conv_t;
    // control outputs towards the converter and pins
    typedef struct packed {
        logic stopSwitching;
        logic dischargeOn;
        logic newSoftStart;
        logic ccmMode;
    } drive_t;
    typedef enum logic [1:0] {
        ROLE_INIT = 2'b00,
        ROLE_SAMPLE = 2'b01,
        ROLE_PRIMARY = 2'b11,
        ROLE_SECONDARY = 2'b10
    } role_t;
endpackage

// ---- verilog/power_good_thermal_fault_logic.sv ----
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "pg_thermal_defs.svh"
module power_good_thermal_fault_logic (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire pg_thermal_pkg::pins_t pins,
    input wire pg_thermal_pkg::conv_t conv,
    output pg_thermal_pkg::drive_t drive,
    output logic powerGoodOut,
    output logic powerGoodOe,
    output logic enPinOut,
    output logic enPinOe
);
    import pg_thermal_pkg::*;

    localparam logic [11:0] DGL_LAST = 12'(`DEGLITCH_CYCLES - 1);

    function automatic logic isReg(input logic [7:0] a, input logic [7:0] off);
        isReg = (a[7:2] == off[7:2]);
    endfunction

    pins_t pinMeta_q;
    pins_t pinSync_q;
    role_t roleState_q;
    logic [3:0] ctrl_q;
    logic thermal_warning_flag_q;
    logic tshutFlag_q;
    logic tshutActive_q;
    logic winFault_q;
    logic [11:0] glitchCnt_q;
    logic startupHold_q;
    logic ccmLatch_q;
    logic pgSyncPrev_q;
    logic busPending_q;
    logic busWrite_q;
    logic [7:0] busAddr_q;
    logic readClear;
    logic winRaw;
    logic winBad;
    logic enabled;
    logic stackDisable;
    logic pgGood;
    logic isPrimary;
    logic isSecondary;
    logic [31:0] statusWord;

    // two flops on every pin and comparator before any use; no reset, so the
    // pair keeps tracking the pins during reset and the role sample sees the real pin
    always_ff @(posedge clk_sys) begin
        pinMeta_q <= pins;
        pinSync_q <= pinMeta_q;
    end

    // role is sensed once after reset; init state waits one cycle for sync flops to fill
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            roleState_q <= ROLE_INIT;
        end else begin
            unique case (roleState_q)
                ROLE_INIT: begin
                    roleState_q <= ROLE_SAMPLE;
                end
                ROLE_SAMPLE: begin
                    // resistor to ground reads low, open pin reads high
                    roleState_q <= pinSync_q.syncOutputPinHigh ? ROLE_PRIMARY
                                                               : ROLE_SECONDARY; // R18
                end
                ROLE_PRIMARY: begin
                    roleState_q <= ROLE_PRIMARY;
                end
                ROLE_SECONDARY: begin
                    roleState_q <= ROLE_SECONDARY;
                end
            endcase
        end
    end

    assign isPrimary = (roleState_q == ROLE_PRIMARY);
    assign isSecondary = (roleState_q == ROLE_SECONDARY);

    // raw window fault, outside the 95..105 percent band
    assign winRaw = pinSync_q.vBelowWindow | pinSync_q.vAboveWindow; // R3

    // deglitch: a new level passes only after staying stable the whole interval
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            winFault_q <= 1'b0;
            glitchCnt_q <= '0;
        end else if (winRaw == winFault_q) begin
            glitchCnt_q <= '0; // R20
        end else if (glitchCnt_q == DGL_LAST) begin
            winFault_q <= winRaw; // R4
            glitchCnt_q <= '0;
        end else begin
            glitchCnt_q <= glitchCnt_q + 12'h0001; // R20
        end
    end

    // thermal shutdown state with hysteresis between 170 and 150
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tshutActive_q <= 1'b0;
        end else if (pinSync_q.tAbove170) begin
            tshutActive_q <= 1'b1; // R14
        end else if (!pinSync_q.tAbove150) begin
            tshutActive_q <= 1'b0; // R16
        end
    end

    assign enabled = pinSync_q.enPin & ctrl_q[`CTRL_SW_ENABLE_BIT];
    // blanking applies only while a voltage transition is running
    assign winBad = winFault_q & ~(ctrl_q[`CTRL_BLANK_BIT] & conv.dynamicVoltageTransition); // R5
    assign pgGood = enabled
                  & ~pinSync_q.undervoltageLockout
                  & ~pinSync_q.overvoltageLockout
                  & ~conv.softStartActive
                  & ~conv.hiccupActive
                  & ~tshutActive_q
                  & ~winBad; // R6 R7
    assign stackDisable = ~enabled | tshutActive_q | pinSync_q.undervoltageLockout;

    // secondary latches; preset is the DCM-allowed state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            startupHold_q <= 1'b1; // R8
            ccmLatch_q <= 1'b0;
            pgSyncPrev_q <= 1'b0;
        end else begin
            pgSyncPrev_q <= pinSync_q.powerGoodPin;
            if (stackDisable) begin
                startupHold_q <= 1'b1; // R11
                ccmLatch_q <= 1'b0; // R11
            end else begin
                if (conv.startupDone) begin
                    startupHold_q <= 1'b0; // R9
                end
                // line only rises once every device has let go of it
                if (isSecondary && !startupHold_q
                    && pinSync_q.powerGoodPin && !pgSyncPrev_q) begin
                    ccmLatch_q <= 1'b1; // R2 R10
                end
            end
        end
    end

    // open-drain power-good: output value is always low, only enable moves
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            powerGoodOut <= 1'b0;
            powerGoodOe <= 1'b1;
        end else begin
            powerGoodOut <= 1'b0;
            if (isPrimary) begin
                powerGoodOe <= ~pgGood; // R1 R7
            end else if (isSecondary) begin
                powerGoodOe <= startupHold_q; // R9
            end else begin
                powerGoodOe <= 1'b1; // held low until the role is known
            end
        end
    end

    // enable pin pull-down also disables the rest of the stack
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enPinOut <= 1'b0;
            enPinOe <= 1'b0;
        end else begin
            enPinOut <= 1'b0;
            enPinOe <= tshutActive_q & ~ctrl_q[`CTRL_STANDALONE_BIT]; // R15 R19
        end
    end

    // converter controls; restart is a pulse on leaving shutdown
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            drive <= '0;
        end else begin
            drive.stopSwitching <= tshutActive_q; // R14
            drive.dischargeOn <= ctrl_q[`CTRL_DISCHARGE_BIT]
                                 & (tshutActive_q | ~enabled
                                    | pinSync_q.undervoltageLockout
                                    | pinSync_q.overvoltageLockout); // R14
            drive.newSoftStart <= tshutActive_q & ~pinSync_q.tAbove170
                                  & ~pinSync_q.tAbove150; // R16
            drive.ccmMode <= isSecondary & ccmLatch_q;
        end
    end

    // bus: address phase taken, one wait cycle, then data phase ends
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busPending_q <= 1'b0;
            busWrite_q <= 1'b0;
            busAddr_q <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0; // always okay
            if (busPending_q) begin
                busPending_q <= 1'b0;
                hreadyout <= 1'b1;
            end else if (hsel && htrans[1] && hready) begin
                busPending_q <= 1'b1;
                busWrite_q <= hwrite;
                busAddr_q <= haddr;
                hreadyout <= 1'b0;
            end
        end
    end

    assign readClear = busPending_q & ~busWrite_q & isReg(busAddr_q, `STATUS_OFFSET);

    // control register written in the wait cycle while hwdata stands
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= `CTRL_RESET;
        end else if (busPending_q && busWrite_q && isReg(busAddr_q, `CTRL_OFFSET)) begin
            ctrl_q <= hwdata[3:0];
        end
    end

    // sticky flags: a set in the clearing cycle wins over the clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            thermal_warning_flag_q <= 1'b0;
            tshutFlag_q <= 1'b0;
        end else begin
            if (pinSync_q.tAbove150) begin
                thermal_warning_flag_q <= 1'b1; // R12
            end else if (readClear && !pinSync_q.tAbove130) begin
                thermal_warning_flag_q <= 1'b0; // R13
            end
            if (pinSync_q.tAbove170) begin
                tshutFlag_q <= 1'b1; // R14
            end else if (readClear && !pinSync_q.tAbove150) begin
                tshutFlag_q <= 1'b0; // R17
            end
        end
    end

    always_comb begin
        statusWord = '0;
        statusWord[`STAT_THERMAL_WARNING_FLAG_BIT] = thermal_warning_flag_q;
        statusWord[`STAT_THERMAL_SHUTDOWN_FLAG_BIT] = tshutFlag_q;
        statusWord[`STAT_SECONDARY_BIT] = isSecondary;
        statusWord[`STAT_PG_LOW_BIT] = powerGoodOe;
        statusWord[`STAT_CCM_BIT] = ccmLatch_q;
        statusWord[`STAT_HOLD_BIT] = startupHold_q;
        statusWord[`STAT_WINDOW_BIT] = winFault_q;
        statusWord[`STAT_ROLE_KNOWN_BIT] = roleState_q[1];
    end

    // read data registered so it is valid for the whole final data cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hrdata <= '0;
        end else if (busPending_q && !busWrite_q) begin
            if (isReg(busAddr_q, `CTRL_OFFSET)) begin
                hrdata <= {28'h000_0000, ctrl_q};
            end else if (isReg(busAddr_q, `STATUS_OFFSET)) begin
                hrdata <= statusWord;
            end else begin
                hrdata <= 32'h0000_0000; // unmapped reads as zero
            end
        end
    end

    AST_PG_LOW_THERMAL_SHUTDOWN_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
        isPrimary && tshutActive_q |=> powerGoodOe) // R6
        else $error("power-good released during thermal shutdown");

    AST_PG_RELEASE: assert property (@(posedge clk_sys) disable iff (rst)
        isPrimary && pgGood |=> !powerGoodOe) // R7
        else $error("power-good not released with all conditions good");

    AST_DEGLITCH_STABLE: assert property (@(posedge clk_sys) disable iff (rst)
        $changed(winFault_q) |-> $past(glitchCnt_q) == DGL_LAST) // R4
        else $error("window fault passed before deglitch interval");

    AST_THERMAL_WARNING_FLAG_SET: assert property (@(posedge clk_sys) disable iff (rst)
        pinSync_q.tAbove150 |=> thermal_warning_flag_q) // R12
        else $error("thermal warning not set");

    AST_THERMAL_WARNING_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        readClear && pinSync_q.tAbove130 && thermal_warning_flag_q |=> thermal_warning_flag_q) // R13
        else $error("thermal warning cleared while still hot");

    AST_THERMAL_SHUTDOWN_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
        readClear && !pinSync_q.tAbove150 && !pinSync_q.tAbove170 |=> !tshutFlag_q) // R17
        else $error("shutdown flag not cleared by cool read");

    AST_EN_PULL: assert property (@(posedge clk_sys) disable iff (rst)
        tshutActive_q && !ctrl_q[`CTRL_STANDALONE_BIT] |=> enPinOe) // R15
        else $error("enable pin not pulled in shutdown");

    AST_SEC_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        isSecondary && $past(isSecondary) && startupHold_q |=> powerGoodOe) // R8
        else $error("secondary released line while holding");

    AST_LATCH_PRESET: assert property (@(posedge clk_sys) disable iff (rst)
        stackDisable |=> startupHold_q && !ccmLatch_q) // R11
        else $error("secondary latches not preset on disable");

    AST_BUS_WAIT: assert property (@(posedge clk_sys) disable iff (rst)
        hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
        else $error("bus answer not after one wait cycle");

    CVR_SHUTDOWN_EXIT: cover property (@(posedge clk_sys) disable iff (rst)
        $fell(tshutActive_q));
    CVR_CCM_ENTRY: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(ccmLatch_q));
    CVR_PG_RELEASE: cover property (@(posedge clk_sys) disable iff (rst)
        isPrimary && $fell(powerGoodOe));
    CVR_BLANKED: cover property (@(posedge clk_sys) disable iff (rst)
        winFault_q && !winBad && pgGood);
endmodule

// ---- tb/stack_partner_model.sv ----
`timescale 1ns/100ps
// other converter of the stack, sharing the power-good and enable lines
module stack_partner_model (
    input wire logic clk_sys,
    input wire logic startDone,
    input wire logic hot,
    output logic pgPullLow,
    output logic enPullLow
);
    // holds the shared lines low from its own state; lines are pulled up elsewhere
    always @(posedge clk_sys) begin
        pgPullLow <= !startDone;
        enPullLow <= hot;
    end
endmodule

// ---- tb/power_good_thermal_fault_logic_tb.sv ----
`timescale 1ns/100ps
`include "pg_thermal_defs.svh"
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin numErrors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module power_good_thermal_fault_logic_tb;
    import pg_thermal_pkg::*;
    logic clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, r;
    pins_t pinsDrv, pinsBus;
    conv_t conv;
    drive_t drive;
    logic powerGoodOut, powerGoodOe, enPinOut, enPinOe;
    logic partnerDone = 1, partnerHot = 0, partnerPgLow, partnerEnLow;
    logic pgLine, enLine;
    int numErrors = 0, numChecks = 0, cycles = 0, n;
    // shared lines are open drain with pull-ups
    assign pgLine = !(powerGoodOe | partnerPgLow);
    assign enLine = !(enPinOe | partnerEnLow);
    always_comb begin
        pinsBus = pinsDrv;
        pinsBus.enPin = enLine;
        pinsBus.powerGoodPin = pgLine;
    end
    always #5 clk_sys = ~clk_sys;
    power_good_thermal_fault_logic i_power_good_thermal_fault_logic (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pinsBus),
        .conv(conv), .drive(drive), .powerGoodOut(powerGoodOut),
        .powerGoodOe(powerGoodOe), .enPinOut(enPinOut), .enPinOe(enPinOe));
    stack_partner_model i_stack_partner_model (.clk_sys(clk_sys), .startDone(partnerDone),
        .hot(partnerHot), .pgPullLow(partnerPgLow), .enPullLow(partnerEnLow));
    task complete_run;
        $display("checks %0d mismatches %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // a hang counts as a mismatch; the full run needs at most about 24300 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 60000) begin
            numErrors++;
            complete_run();
        end
    end
    task tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // one single word transfer; waits as long as the slave stretches either phase
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task doReset;
        rst <= 1'b1;
        tick(5);
        rst <= 1'b0;
        tick(3);
    endtask
    // expected pull-down of a primary from filtered fault, blanking and hard conditions
    function logic expPgLow(logic flt, logic blank, logic dvt, logic bad);
        return bad | (flt & !(blank & dvt));
    endfunction
    initial begin
        pinsDrv = '0;
        pinsDrv.syncOutputPinHigh = 1'b1;
        conv = '0;
        void'($urandom(9940));
        doReset();
        bus(0, `CTRL_OFFSET, 0);
        `CHK(r, 32'h0000_0003)
        bus(1, 8'h3c, 32'hffff_ffff);
        bus(0, 8'h3c, 0);
        `CHK(r, 32'h0000_0000)
        `CHK(hresp, 1'b0)
        `CHK(powerGoodOut, 1'b0)
        `CHK(enPinOut, 1'b0)
        $display("test registers done");
        tick(8);
        `CHK(powerGoodOe, 1'b0)
        // each hard condition alone must pull power-good low
        for (int i = 0; i < 5; i++) begin
            conv.softStartActive <= (i == 0);
            conv.hiccupActive <= (i == 1);
            pinsDrv.undervoltageLockout <= (i == 2);
            pinsDrv.overvoltageLockout <= (i == 3);
            if (i == 4) bus(1, `CTRL_OFFSET, 32'h0000_0002);
            tick(6);
            `CHK(powerGoodOe, 1'b1)
            conv <= '0;
            pinsDrv.undervoltageLockout <= 1'b0;
            pinsDrv.overvoltageLockout <= 1'b0;
            if (i == 4) bus(1, `CTRL_OFFSET, 32'h0000_0003);
            tick(6);
            `CHK(powerGoodOe, 1'b0)
        end
        $display("test conditions done");
        n = $urandom_range(3900, 100);
        pinsDrv.vBelowWindow <= 1'b1;
        tick(n);
        pinsDrv.vBelowWindow <= 1'b0;
        tick(4100);
        `CHK(powerGoodOe, 1'b0)
        pinsDrv.vAboveWindow <= 1'b1;
        tick(3990);
        `CHK(powerGoodOe, 1'b0)
        tick(20);
        `CHK(powerGoodOe, 1'b1)
        pinsDrv.vAboveWindow <= 1'b0;
        tick(4010);
        `CHK(powerGoodOe, 1'b0)
        bus(1, `CTRL_OFFSET, 32'h0000_0007);
        conv.dynamicVoltageTransition <= 1'b1;
        pinsDrv.vBelowWindow <= 1'b1;
        tick(4010);
        `CHK(powerGoodOe, expPgLow(1, 1, 1, 0))
        bus(1, `CTRL_OFFSET, 32'h0000_0003);
        tick(4);
        `CHK(powerGoodOe, expPgLow(1, 0, 1, 0))
        pinsDrv.vBelowWindow <= 1'b0;
        conv.dynamicVoltageTransition <= 1'b0;
        tick(4010);
        `CHK(powerGoodOe, 1'b0)
        $display("test window done");
        pinsDrv.tAbove130 <= 1'b1;
        pinsDrv.tAbove150 <= 1'b1;
        tick(6);
        bus(0, `STATUS_OFFSET, 0);
        `CHK(r[`STAT_THERMAL_WARNING_FLAG_BIT], 1'b1)
        pinsDrv.tAbove150 <= 1'b0;
        tick(6);
        bus(0, `STATUS_OFFSET, 0);
        `CHK(r[`STAT_THERMAL_WARNING_FLAG_BIT], 1'b1)
        pinsDrv.tAbove130 <= 1'b0;
        tick(6);
        bus(0, `STATUS_OFFSET, 0);
        bus(0, `STATUS_OFFSET, 0);
        `CHK(r[`STAT_THERMAL_WARNING_FLAG_BIT], 1'b0)
        // shutdown with standalone-select and discharge enable both ways
        for (int s = 0; s < 2; s++) begin
            bus(1, `CTRL_OFFSET, {28'h0, s[0], 1'b0, !s[0], 1'b1});
            pinsDrv.tAbove130 <= 1'b1;
            pinsDrv.tAbove150 <= 1'b1;
            pinsDrv.tAbove170 <= 1'b1;
            tick(6);
            `CHK(drive.stopSwitching, 1'b1)
            `CHK(drive.dischargeOn, !s[0])
            `CHK(powerGoodOe, 1'b1)
            `CHK(enPinOe, !s[0])
            pinsDrv.tAbove170 <= 1'b0;
            tick(6);
            bus(0, `STATUS_OFFSET, 0);
            `CHK(r[`STAT_THERMAL_SHUTDOWN_FLAG_BIT], 1'b1)
            pinsDrv.tAbove150 <= 1'b0;
            pinsDrv.tAbove130 <= 1'b0;
            tick(10);
            `CHK(drive.stopSwitching, 1'b0)
            `CHK(enPinOe, 1'b0)
            `CHK(powerGoodOe, 1'b0)
            bus(0, `STATUS_OFFSET, 0);
            bus(0, `STATUS_OFFSET, 0);
            `CHK(r[`STAT_THERMAL_SHUTDOWN_FLAG_BIT], 1'b0)
        end
        $display("test thermal done");
        pinsDrv.syncOutputPinHigh <= 1'b0;
        partnerDone <= 1'b0;
        doReset();
        bus(0, `STATUS_OFFSET, 0);
        `CHK(r[`STAT_SECONDARY_BIT], 1'b1)
        `CHK(r[`STAT_HOLD_BIT], 1'b1)
        `CHK(powerGoodOe, 1'b1)
        conv.startupDone <= 1'b1;
        tick(6);
        `CHK(powerGoodOe, 1'b0)
        `CHK(drive.ccmMode, 1'b0)
        partnerDone <= 1'b1;
        tick(6);
        `CHK(drive.ccmMode, 1'b1)
        partnerHot <= 1'b1;
        tick(6);
        `CHK(drive.ccmMode, 1'b0)
        `CHK(powerGoodOe, 1'b1)
        partnerHot <= 1'b0;
        tick(12);
        `CHK(drive.ccmMode, 1'b1)
        $display("test secondary done");
        complete_run();
    end
endmodule
